// ==== core/tc_com.sv ====
// Purpose: Communication unit end: word image and AXI4-Lite register slave
// Assumes: Same clock as the module end; one read and one write at a time
// Notes: Addresses above bit 13 are ignored
`timescale 1ns/1ns
`include "tc_regs.svh"
module tc_com (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // AXI4-Lite write
  input  wire logic [31:0] AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  // AXI4-Lite read
  input  wire logic [31:0] ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Full set of four words received
  output logic             SET_DONE_O,
  // Link to the thermocouple module
  tc_link_if.com           link
);
  import tc_pkg::*;

  localparam logic [13:0] SP_A = `TC_OFF_SPROC + 14'(8 * `TC_SLOT_NUM);
  localparam logic [13:0] ST_A = `TC_OFF_SSTAT + 14'(4 * `TC_SLOT_NUM);
  localparam logic [13:0] TY_A = `TC_OFF_STYPE + 14'(4 * `TC_SLOT_NUM);
  localparam logic [13:0] SB_A = `TC_OFF_SBITS + 14'(32 * `TC_SLOT_NUM);

  word_t       img_ff [4];
  logic [31:0] cfg_ff;
  logic [31:0] scale_ff;
  logic [31:0] chaddr_ff;
  wr_state_t   wr_st_ff;
  logic [13:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        aw_now;
  logic        w_now;
  logic        wr_do;
  logic [13:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [13:0] hold_a;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge_f(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge_f[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge_f

  // Read decode: bit 32 marks a mapped address
  function automatic logic [32:0] rd_f(input logic [13:0] a);
    logic [13:0] d;
    rd_f = 33'h0_0000_0000;
    d    = 14'h0000;
    if (a < `TC_OFF_ALLOC + 14'h0010) begin
      rd_f = {17'h10000, img_ff[a[3:2]]};
    end else if (a >= SP_A && a < SP_A + 14'h0010) begin
      d    = a - SP_A;
      rd_f = {17'h10000, img_ff[d[3:2]]};
    end else if (a == ST_A) begin
      rd_f = {29'h10000000, link.fault};
    end else if (a == TY_A) begin
      rd_f = {17'h10000, `TC_TYPE_CODE};
    end else if (a >= hold_a && a < hold_a + 14'h0010) begin
      d    = a - hold_a;
      rd_f = {17'h10000, img_ff[d[3:2]]};
    end else if (a >= SB_A && a < SB_A + 14'h0020) begin
      d    = a - SB_A;
      rd_f = {32'h80000000, d[4:2] < 3'h4 ? link.fault[d[3:2]] : 1'b0};
    end else if (a == `TC_OFF_CFG) begin
      rd_f = {1'b1, cfg_ff};
    end else if (a == `TC_OFF_SCALE) begin
      rd_f = {1'b1, scale_ff};
    end else if (a == `TC_OFF_CHADDR) begin
      rd_f = {1'b1, chaddr_ff};
    end
    if (a[1:0] != 2'h0) begin
      rd_f = 33'h0_0000_0000;
    end
  endfunction : rd_f

  ////////////////////////////////////////////////////////////////////
  // Word image from the link

  // Direct word offsets only, four bytes per step; one-based numbering is mapped by software
  assign hold_a = `TC_OFF_HOLD + {chaddr_ff[11:0], 2'b00};

  // Store each arriving channel word
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      img_ff     <= '{default: 16'h0000};
      SET_DONE_O <= 1'b0;
    end else begin
      SET_DONE_O <= link.word_stb && (link.word_ch == 2'h3);
      if (link.word_stb) begin
        img_ff[link.word_ch] <= link.word_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write channel

  assign aw_now = AWVALID_I && AWREADY_O;
  assign w_now  = WVALID_I && WREADY_O;
  assign wa     = aw_now ? AWADDR_I[13:0] : awaddr_ff;
  assign wd     = w_now ? WDATA_I : wdata_ff;
  assign ws     = w_now ? WSTRB_I : wstrb_ff;
  assign wr_do  = (wr_st_ff == WR_COLLECT) && (aw_now || !AWREADY_O)
               && (w_now || !WREADY_O);

  // Address and data in either order, then one response
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_st_ff  <= WR_COLLECT;
      AWREADY_O <= 1'b1;
      WREADY_O  <= 1'b1;
      BVALID_O  <= 1'b0;
      BRESP_O   <= 2'h0;
      awaddr_ff <= 14'h0000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      unique case (wr_st_ff)
        WR_COLLECT: begin
          if (aw_now) begin
            AWREADY_O <= 1'b0;
            awaddr_ff <= AWADDR_I[13:0];
          end
          if (w_now) begin
            WREADY_O <= 1'b0;
            wdata_ff <= WDATA_I;
            wstrb_ff <= WSTRB_I;
          end
          if (wr_do) begin
            wr_st_ff  <= WR_RESP;
            AWREADY_O <= 1'b0;
            WREADY_O  <= 1'b0;
            BVALID_O  <= 1'b1;
            BRESP_O   <= (wa == `TC_OFF_CFG || wa == `TC_OFF_SCALE
                       || wa == `TC_OFF_CHADDR) ? 2'h0 : 2'h2;
          end
        end
        WR_RESP: begin
          if (BREADY_I) begin
            wr_st_ff  <= WR_COLLECT;
            BVALID_O  <= 1'b0;
            AWREADY_O <= 1'b1;
            WREADY_O  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_ff    <= `TC_CFG_RST;
      scale_ff  <= `TC_SCALE_RST;
      chaddr_ff <= `TC_CHADDR_RST;
    end else if (wr_do) begin
      if (wa == `TC_OFF_CFG)    cfg_ff    <= merge_f(cfg_ff, wd, ws);
      if (wa == `TC_OFF_SCALE)  scale_ff  <= merge_f(scale_ff, wd, ws);
      if (wa == `TC_OFF_CHADDR) chaddr_ff <= merge_f(chaddr_ff, wd, ws);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read channel

  // Answer one cycle after the address is taken
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= 2'h0;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RDATA_O   <= 32'(rd_f(ARADDR_I[13:0]));  // Bit 32 is the hit flag
      RRESP_O   <= rd_f(ARADDR_I[13:0]) >= 33'h1_0000_0000 ? 2'h0 : 2'h2;
    end else if (RVALID_O && RREADY_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
    end
  end

  // Configuration toward the module
  assign link.lfd_en   = cfg_ff[`TC_CFG_LFD];
  assign link.cj_int   = cfg_ff[`TC_CFG_CJINT];
  assign link.filt_en  = cfg_ff[`TC_CFG_FILT];
  assign link.curve    = cfg_ff[`TC_CFG_CURVE +: 2];
  assign link.holdoff  = cfg_ff[`TC_CFG_HOLD +: 8];
  assign link.scale_lo = scale_ff[15:0];
  assign link.scale_hi = scale_ff[31:16];
endmodule : tc_com

// ==== core/tc_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: System clock of 50 MHz
// Notes: Offsets are AXI4-Lite byte addresses of the communication unit
`ifndef TC_REGS_SVH
`define TC_REGS_SVH
////////////////////////////////////////////////////////////////////////
// Clock rate and times in microseconds, cycle counts derived from them
`define TC_CLK_MHZ      50
`define TC_CYC(us)      ((us) * `TC_CLK_MHZ)
`define TC_PASS_US      200000
`define TC_PASS_LFD_US  350000
`define TC_SLOT_US      6500
`define TC_UNIT_EXT_US  160000
`define TC_UNIT_INT_US  240000
`define TC_PASS_CYC     `TC_CYC(`TC_PASS_US)
`define TC_PASS_LFD_CYC `TC_CYC(`TC_PASS_LFD_US)
`define TC_SLOT_CYC     `TC_CYC(`TC_SLOT_US)
`define TC_UNIT_EXT_CYC `TC_CYC(`TC_UNIT_EXT_US)
`define TC_UNIT_INT_CYC `TC_CYC(`TC_UNIT_INT_US)
////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define TC_OFF_ALLOC    14'h0000
`define TC_OFF_SPROC    14'h0200
`define TC_OFF_SSTAT    14'h0300
`define TC_OFF_STYPE    14'h0400
`define TC_OFF_HOLD     14'h0600
`define TC_OFF_SBITS    14'h0800
`define TC_OFF_CFG      14'h1000
`define TC_OFF_SCALE    14'h1004
`define TC_OFF_CHADDR   14'h1008
`define TC_SLOT_NUM     0
////////////////////////////////////////////////////////////////////////
// Field positions, reset values and fixed codes
`define TC_CFG_LFD      0
`define TC_CFG_CJINT    1
`define TC_CFG_FILT     2
`define TC_CFG_CURVE    4
`define TC_CFG_HOLD     8
`define TC_CFG_RST      32'h0000_0000
`define TC_SCALE_RST    32'hC350_2710
`define TC_CHADDR_RST   32'h0000_0000
`define TC_SCALE_MIN    16'h2710
`define TC_SCALE_MAX    16'hC350
`define TC_TYPE_CODE    16'h5A01
`define TC_FILT_SHIFT   3
`endif

// ==== core/tc_pkg.sv ====
// Purpose: Types shared by both ends of the readout
// Assumes: Nothing beyond the header of constants
// Notes: Holds types only
package tc_pkg;
  typedef logic [15:0] word_t;
  typedef logic [1:0]  chan_t;
  typedef enum logic {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_t;
endpackage : tc_pkg

// ==== core/tc_link_if.sv ====
// Purpose: Link between the thermocouple module and the communication unit
// Assumes: Both ends run on the same clock
// Notes: Channel words flow to the unit, configuration flows back
`timescale 1ns/1ns
interface tc_link_if;
  logic          word_stb;
  tc_pkg::chan_t word_ch;
  tc_pkg::word_t word_data;
  logic [3:0]    fault;
  logic          lfd_en;
  logic          cj_int;
  logic          filt_en;
  logic [1:0]    curve;
  logic [7:0]    holdoff;
  tc_pkg::word_t scale_lo;
  tc_pkg::word_t scale_hi;
  modport dev (output word_stb, word_ch, word_data, fault,
               input lfd_en, cj_int, filt_en, curve, holdoff, scale_lo, scale_hi);
  modport com (input word_stb, word_ch, word_data, fault,
               output lfd_en, cj_int, filt_en, curve, holdoff, scale_lo, scale_hi);
endinterface : tc_link_if

// ==== core/tc_smooth.sv ====
// Purpose: First-order smoothing of one channel's samples
// Assumes: Samples arrive as single-cycle strobes
// Notes: With smoothing off the sample passes unchanged
`timescale 1ns/1ns
`include "tc_regs.svh"
module tc_smooth (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Sample in and out
  input  wire logic          en_i,
  input  wire logic          vld_i,
  input  wire tc_pkg::word_t x_i,
  output logic               vld_o,
  output tc_pkg::word_t      y_o
);
  import tc_pkg::*;

  logic        init_ff;
  word_t       y_ff;
  logic [16:0] diff;
  logic [16:0] step;
  logic [16:0] sum;

  // Move a fraction of the gap toward the new sample
  assign diff = {1'b0, x_i} - {1'b0, y_ff};
  assign step = 17'($signed(diff) >>> `TC_FILT_SHIFT);
  assign sum  = {1'b0, y_ff} + step;

  // Filter state, seeded by the first sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_ff <= 1'b0;
      y_ff    <= 16'h0000;
      vld_o   <= 1'b0;
    end else begin
      vld_o <= vld_i;
      if (vld_i) begin
        init_ff <= 1'b1;
        y_ff    <= (en_i && init_ff) ? sum[15:0] : x_i;
      end
    end
  end

  assign y_o = y_ff;
endmodule : tc_smooth

// ==== core/tc_device.sv ====
// Purpose: Thermocouple module end: pass timing, fault hold-off, word build
// Assumes: Converter codes arrive on MCLK_I; break pins are asynchronous
// Notes: Long counts are parameters so that a simulation can shorten them
//
// Summary of operation
// - Digitise -200 to 1850 C at 16 bits
// - Narrowest 5 mV span gives 2500 steps
// - Pass of four channels takes 200 ms
// - With fault detection a pass takes 350 ms
// - One channel word sent every 6.5 ms
// - Channels sent in turn, full set four slots
// - Value spans unsigned 0 through 65535
// - One 16-bit word, low four bits status
// - No status bits when scaling outside window
// - Bit 1 is line fault, one means fault
// - Twelve-bit value in bits 4 to 15
// - All channels same layout, no output data
// - Holding area mirror at base plus channel address
// - Slot process words at base plus twice slot
// - Status bits at base plus eight per slot
// - Status and type words, one per slot
// - Master picks base matching its numbering
// - Lead breakage detection, switchable per module
// - External junction hold-off 0..250 times 160 ms
// - Internal junction hold-off 0..250 times 240 ms
// - Selectable smoothing filter on inputs
// - Linearize every supported thermocouple curve; curve setting 0 passes converter codes unchanged
`timescale 1ns/1ns
`include "tc_regs.svh"
module tc_device #(
  parameter int PASS_CYC     = `TC_PASS_CYC,
  parameter int PASS_LFD_CYC = `TC_PASS_LFD_CYC,
  parameter int SLOT_CYC     = `TC_SLOT_CYC,
  parameter int UNIT_EXT_CYC = `TC_UNIT_EXT_CYC,
  parameter int UNIT_INT_CYC = `TC_UNIT_INT_CYC
) (
  // Clock and reset
  input  wire logic          MCLK_I,
  input  wire logic          RST_N_I,
  // Converter samples
  input  wire logic          SAMPLE_VALID_I,
  input  wire tc_pkg::chan_t SAMPLE_CH_I,
  input  wire tc_pkg::word_t SAMPLE_I,
  // Lead breakage sense pins
  input  wire logic [3:0]    LINE_BREAK_I,
  // Start of a measurement pass
  output logic               CONV_START_O,
  // Link to the communication unit
  tc_link_if.dev             link
);
  import tc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Bend the converter code toward the curve; codes keep full width
  function automatic word_t lin_f(input word_t c, input logic [1:0] crv);
    logic [31:0] sq;
    sq    = c * c;
    lin_f = c;
    if (crv != 2'h0) begin
      lin_f = c - (sq[31:16] >> crv);
    end
  endfunction : lin_f

  // Build a channel word from value, fault and scaling state
  function automatic word_t pack_f(input word_t v, input logic f, input logic ok);
    pack_f = v;
    if (ok) begin
      pack_f = {v[15:4], 2'b00, f, 1'b0};
    end
  endfunction : pack_f

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [3:0]  lb_s1_ff;
  logic [3:0]  lb_s2_ff;
  logic [3:0]  fault_now;
  logic [24:0] pass_cnt_ff;
  logic [24:0] pass_lim;
  logic [23:0] unit_cnt_ff;
  logic [23:0] unit_lim;
  logic        unit_tick;
  logic [18:0] slot_cnt_ff;
  chan_t       slot_ch_ff;
  logic        scale_ok_ff;
  word_t       lin_word;
  word_t       val_w [4];
  logic [3:0]  flt_w;
  logic        word_stb_ff;
  chan_t       word_ch_ff;
  word_t       word_data_ff;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two stages on the break pins before any logic reads them
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lb_s1_ff <= 4'h0;
      lb_s2_ff <= 4'h0;
    end else begin
      lb_s1_ff <= LINE_BREAK_I;
      lb_s2_ff <= lb_s1_ff;
    end
  end

  // Breakage only counts while detection is on
  assign fault_now = link.lfd_en ? lb_s2_ff : 4'h0;

  ////////////////////////////////////////////////////////////////////
  // Measurement pass timing

  // Pass length depends on fault detection
  assign pass_lim = link.lfd_en ? 25'(PASS_LFD_CYC - 1)
                                : 25'(PASS_CYC - 1);

  // Pass counter; pulses a conversion start at each wrap
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pass_cnt_ff  <= 25'h0000000;
      CONV_START_O <= 1'b0;
    end else if (pass_cnt_ff >= pass_lim) begin
      pass_cnt_ff  <= 25'h0000000;
      CONV_START_O <= 1'b1;
    end else begin
      pass_cnt_ff  <= pass_cnt_ff + 25'h0000001;
      CONV_START_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Hold-off time base

  // Unit length follows the cold junction source
  assign unit_lim = link.cj_int ? 24'(UNIT_INT_CYC - 1)
                                : 24'(UNIT_EXT_CYC - 1);
  assign unit_tick = (unit_cnt_ff >= unit_lim);

  // Free-running unit counter shared by all channels
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      unit_cnt_ff <= 24'h000000;
    end else if (unit_tick) begin
      unit_cnt_ff <= 24'h000000;
    end else begin
      unit_cnt_ff <= unit_cnt_ff + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample path

  // Converter codes keep all 16 bits, so a 5 mV span keeps its 2500 steps
  assign lin_word = lin_f(SAMPLE_I, link.curve);

  // Status window check on the configured scaling
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scale_ok_ff <= 1'b0;
    end else begin
      scale_ok_ff <= (link.scale_lo >= `TC_SCALE_MIN)
                  && (link.scale_hi <= `TC_SCALE_MAX);
    end
  end

  // One smoothing stage, fault state and value store per channel
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic       hit;
    logic       sm_vld;
    word_t      sm_val;
    logic       flt_ff;
    logic [7:0] hold_ff;
    word_t      val_ff;

    assign hit = SAMPLE_VALID_I && (SAMPLE_CH_I == chan_t'(i));

    tc_smooth u_smooth (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .en_i    (link.filt_en),
      .vld_i   (hit),
      .x_i     (lin_word),
      .vld_o   (sm_vld),
      .y_o     (sm_val)
    );

    // Fault latches, then counts down the hold-off before release
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        flt_ff  <= 1'b0;
        hold_ff <= 8'h00;
      end else if (fault_now[i]) begin
        flt_ff  <= 1'b1;
        hold_ff <= link.holdoff;
      end else if (flt_ff) begin
        if (hold_ff == 8'h00) begin
          flt_ff <= 1'b0;
        end else if (unit_tick) begin
          hold_ff <= hold_ff - 8'h01;
        end
      end
    end

    // Values are withheld while the channel is faulted or holding off
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        val_ff <= 16'h0000;
      end else if (sm_vld && !flt_ff && !fault_now[i]) begin
        val_ff <= sm_val;
      end
    end

    assign val_w[i] = val_ff;
    assign flt_w[i] = flt_ff;
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer slots

  // Slot timer, one word per interval, channels in turn
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slot_cnt_ff <= 19'h00000;
      slot_ch_ff  <= 2'h0;
    end else if (slot_cnt_ff >= 19'(SLOT_CYC - 1)) begin
      slot_cnt_ff <= 19'h00000;
      slot_ch_ff  <= slot_ch_ff + 2'h1;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 19'h00001;
    end
  end

  // Word strobe and payload toward the unit
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      word_stb_ff  <= 1'b0;
      word_ch_ff   <= 2'h0;
      word_data_ff <= 16'h0000;
    end else if (slot_cnt_ff >= 19'(SLOT_CYC - 1)) begin
      word_stb_ff  <= 1'b1;
      word_ch_ff   <= slot_ch_ff;
      // Same layout for every channel
      // Inside the scaling window: fault on bit 1, value in 15:4, rest zero
      word_data_ff <= pack_f(val_w[slot_ch_ff], flt_w[slot_ch_ff],
                             scale_ok_ff);
    end else begin
      word_stb_ff  <= 1'b0;
    end
  end

  // Link outputs, all from flip-flops; nothing flows back as data
  assign link.word_stb  = word_stb_ff;
  assign link.word_ch   = word_ch_ff;
  assign link.word_data = word_data_ff;
  assign link.fault     = flt_w;
endmodule : tc_device

// ==== bench/tc_assertions.sv ====
// Purpose: Link checks between module end and unit end
// Assumes: One clock; SLOT_CYC matches the module end
// Notes: Takes tc_link_if signals as plain inputs
`timescale 1ns/1ns
module tc_assertions #(
  parameter int SLOT_CYC = 20
) (
  // Clock and reset
  input  wire logic          MCLK_I,
  input  wire logic          RST_N_I,
  // Link signals
  input  wire logic          word_stb,
  input  wire tc_pkg::chan_t word_ch,
  input  wire tc_pkg::word_t word_data,
  input  wire logic [3:0]    fault,
  input  wire logic          lfd_en,
  input  wire tc_pkg::word_t scale_lo,
  input  wire tc_pkg::word_t scale_hi
);
  import tc_pkg::*;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  logic  seen_ff;
  chan_t last_ch_ff;
  logic  win;
  logic [1:0] win_sr_ff;
  ////////////////////////////////////////////////////////////////////////
  // Remember the channel of the last word
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seen_ff    <= 1'b0;
      last_ch_ff <= 2'h0;
    end else if (word_stb) begin
      seen_ff    <= 1'b1;
      last_ch_ff <= word_ch;
    end
  end
  // Scaling window that carries status bits
  assign win = (scale_lo >= 16'h2710) && (scale_hi <= 16'hC350);
  // Window as the module end saw it when it built the word now shown
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      win_sr_ff <= 2'b11;
    end else begin
      win_sr_ff <= {win_sr_ff[0], win};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_stb_single: assert property (word_stb |=> !word_stb)
    else $error("word strobe longer than one cycle");
  a_slot_gap: assert property (word_stb |-> ##SLOT_CYC word_stb)
    else $error("word strobe spacing wrong");
  a_quiet_start: assert property ($rose(RST_N_I) |-> !word_stb [*8])
    else $error("word strobe too soon after reset");
  a_ch_first: assert property (word_stb && !seen_ff |-> word_ch == 2'h0)
    else $error("first word not channel 0");
  a_ch_next: assert property (word_stb && seen_ff
    |-> word_ch == chan_t'(last_ch_ff + 2'h1))
    else $error("channel order broken");
  a_status_zero: assert property (word_stb && win_sr_ff[1]
    |-> word_data[3:2] == 2'h0 && !word_data[0])
    else $error("unused status bits not zero");
  a_fault_bit: assert property (word_stb && win_sr_ff[1] && $stable(fault)
    |-> word_data[1] == fault[word_ch])
    else $error("fault bit differs from fault state");
  a_data_hold: assert property (!$stable(word_data) |-> word_stb)
    else $error("word data changed without strobe");
  a_fault_lfd: assert property ((|(fault & ~$past(fault))) |-> $past(lfd_en))
    else $error("fault raised with detection off");
  // Main scenarios
  c_last_ch: cover property (word_stb && word_ch == 2'h3);
  c_fault_word: cover property (word_stb && word_data[1]);
  c_no_status: cover property (word_stb && !win);
endmodule : tc_assertions

// ==== bench/testbench.sv ====
// Purpose: Both ends joined, register access over AXI4-Lite
// Assumes: Shortened counts: slot 20, pass 40/70, units 16/24
// Notes: Response ready raised per transfer until the answer is seen
`timescale 1ns/1ns
module testbench;
  import tc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic        bready, rready;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        set_done, conv, smp_v;
  chan_t       smp_ch;
  word_t       smp_d, v;
  logic [3:0]  brk;
  int          n_fail = 0;
  int          samples_checked = 0;
  tc_link_if link();
  tc_device #(.PASS_CYC(40), .PASS_LFD_CYC(70), .SLOT_CYC(20), .UNIT_EXT_CYC(16),
    .UNIT_INT_CYC(24)) i_tc_device (.MCLK_I(clk), .RST_N_I(rst_n),
    .SAMPLE_VALID_I(smp_v), .SAMPLE_CH_I(smp_ch), .SAMPLE_I(smp_d),
    .LINE_BREAK_I(brk), .CONV_START_O(conv), .link(link));
  tc_com i_tc_com (.MCLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SET_DONE_O(set_done),
    .link(link));
  tc_assertions i_tc_assertions (.MCLK_I(clk), .RST_N_I(rst_n),
    .word_stb(link.word_stb), .word_ch(link.word_ch), .word_data(link.word_data),
    .fault(link.fault), .lfd_en(link.lfd_en), .scale_lo(link.scale_lo),
    .scale_hi(link.scale_hi));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // AXI4-Lite write, both channels offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (!bvalid) bready <= 1'b1;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask : wr
  // AXI4-Lite read
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (!rvalid) rready <= 1'b1;
    end while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
  endtask : rd
  // One converter sample
  task automatic smp(input chan_t c, input word_t d);
    smp_v <= 1'b1;
    smp_ch <= c;
    smp_d <= d;
    @(posedge clk);
    smp_v <= 1'b0;
    @(posedge clk);
  endtask : smp
  // Two full sets so every channel word is refreshed
  task automatic wait_set;
    repeat (2) do @(posedge clk); while (!set_done);
  endtask : wait_set
  // Cycles between two pass starts
  task automatic gap(input int e);
    int n;
    n = 0;
    do @(posedge clk); while (!conv);
    do begin
      @(posedge clk);
      n++;
    end while (!conv);
    check(n, e);
  endtask : gap
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #10 clk = ~clk;
  initial begin
    #300us;
    n_fail++;
    summarize();
  end
  // Test sequence
  initial begin
    {awaddr, wdata, araddr, awvalid, wvalid, arvalid, smp_v, smp_ch, smp_d, brk} = '0;
    {bready, rready, wstrb} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(32'h1000, 32'h0, 2'h0);
    rd(32'h1004, 32'hC350_2710, 2'h0);
    rd(32'h0400, 32'h5A01, 2'h0);
    rd(32'h1FFC, 32'h0, 2'h2);
    wr(32'h0200, 32'h1, 2'h2);
    wr(32'h1008, 32'h1, 2'h0);
    gap(40);
    for (int i = 0; i < 4; i++) smp(chan_t'(i), 16'h1357 + 16'h2020 * 16'(i));
    wait_set();
    for (int i = 0; i < 4; i++) begin
      v = 16'h1357 + 16'h2020 * 16'(i);
      rd(32'(4 * i), {16'h0, v[15:4], 4'h0}, 2'h0);
      rd(32'h200 + 32'(4 * i), {16'h0, v[15:4], 4'h0}, 2'h0);
      rd(32'h604 + 32'(4 * i), {16'h0, v[15:4], 4'h0}, 2'h0);
    end
    // Detection on, hold-off two units, break on channel 1
    wr(32'h1000, 32'h0000_0201, 2'h0);
    gap(70);
    brk <= 4'h2;
    wait_set();
    rd(32'h0004, 32'h3372, 2'h0);
    rd(32'h0300, 32'h2, 2'h0);
    rd(32'h0804, 32'h1, 2'h0);
    smp(2'h1, 16'hFFFF);
    brk <= 4'h0;
    rd(32'h0300, 32'h2, 2'h0);
    repeat (60) @(posedge clk);
    rd(32'h0300, 32'h0, 2'h0);
    wait_set();
    rd(32'h0004, 32'h3370, 2'h0);
    // Smoothing on channel 3, then curve 1 by a one-lane write
    wr(32'h1000, 32'h4, 2'h0);
    smp(2'h3, 16'h7BB7);
    wr(32'h1000, 32'hFFFF_FF10, 2'h0, 4'h1);
    rd(32'h1000, 32'h10, 2'h0);
    smp(2'h2, 16'h8000);
    wait_set();
    rd(32'h000C, 32'h74B0, 2'h0);
    rd(32'h0008, 32'h6000, 2'h0);
    // Scaling outside the window drops the status bits
    wr(32'h1004, 32'hC350_0100, 2'h0);
    wait_set();
    rd(32'h0000, 32'h1357, 2'h0);
    wr(32'h1004, 32'hC351_2710, 2'h0);
    wait_set();
    rd(32'h0004, 32'h3377, 2'h0);
    summarize();
  end
endmodule : testbench
